// >>> rtl/gpdm_regs.svh
`ifndef GPDM_REGS_SVH
`define GPDM_REGS_SVH
// Register byte addresses (word aligned, Avalon-MM word address = byte/4)
`define GPDM_OFF_PA_DATA     6'h00
`define GPDM_OFF_PA_DIR      6'h04
`define GPDM_OFF_PB_DATA     6'h08
`define GPDM_OFF_PB_DIR      6'h0C
`define GPDM_OFF_PC_DATA     6'h10
`define GPDM_OFF_PC_DIR      6'h14
`define GPDM_OFF_PA_FSEL     6'h18
`define GPDM_OFF_PB_FSEL     6'h1C
`define GPDM_OFF_PA_WAKE     6'h20
`define GPDM_OFF_STATUS      6'h24
// Reset values
`define GPDM_RST_PA_DATA     8'hFF
`define GPDM_RST_PA_DIR      8'hFF
`define GPDM_RST_PB_DATA     7'h7F
`define GPDM_RST_PB_DIR      7'h7F
`define GPDM_RST_PC_DATA     3'h7
`define GPDM_RST_PC_DIR      3'h7
`define GPDM_RST_PA_FSEL     8'h00
`define GPDM_RST_PB_FSEL     7'h00
`define GPDM_RST_PA_WAKE     8'h00
// Field positions
`define GPDM_PBF_CLKOUT      4
`define GPDM_PBF_AN7         3
`define GPDM_STS_WAKE        0
`endif

// >>> rtl/gpdm_pkg.sv
package gpdm_pkg;
    typedef struct packed {
        logic [7:0] a;
        logic [6:0] b;
        logic [2:0] c;
    } gpdm_pins_t;

    typedef struct packed {
        logic t0_primary;
        logic t0_inverted;
        logic t1_primary;
        logic t1_inverted;
    } gpdm_timer_out_t;

    typedef struct packed {
        logic [7:0] analog_sel;
        logic       vref_in_sel;
        logic       vref_out_sel;
        logic       timer0_clock_input;
        logic       timer1_clock_input;
        logic       ext_int_zero;
        logic       ext_int_one;
    } gpdm_periph_in_t;

    typedef enum logic [1:0] {
        GPDM_BUS_IDLE = 2'b01,
        GPDM_BUS_ACK  = 2'b10
    } gpdm_bus_state_t;
endpackage

// >>> rtl/gpdm_port.sv
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "gpdm_regs.svh"

// What this block does
// - Direction bit one makes the pin input; reads return live pin level.
// - Direction bit zero makes the pin a push-pull output.
// - Reads of an output pin return the output latch, not the pin.
// - Reset sets all data and direction bits to one.
// - Port B direction has bits 6..0; bit 7 reads zero.
// - Port C direction has bits 2..0; bits 7..3 read zero.
// - Port A select 7:6: 00/10 I/O, 01 timer1 primary, 11 analog six.
// - Port A select 5:4: 0X I/O, 10 reference out, 11 analog five.
// - Port A select 3:2: 0X I/O, 10 reference in, 11 analog four.
// - Port A select bit 1: I/O plus timer1 clock, or analog three.
// - Port B select bit 4 gives clock output only while LCD common two off.
// - Port B select bit 3 gives analog seven only while LCD common three off.
// - Port B select bit 7 is unimplemented and reads zero.
// - Analog function wins over any digital function on a pin.
// - One pin feeding several analog modules feeds all of them.
// - Clock output drives the system clock, at most 8 MHz.
// - Bit set/clear is read-modify-write of the whole port byte.
// - Output latch holds until rewritten; inputs sampled when read.
// - Falling edge on a wake-enabled port A pin wakes the device.
module gpdm_port (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic [3:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    output logic                           avs_response_err,
    input  wire gpdm_pkg::gpdm_pins_t      pin_in,
    output gpdm_pkg::gpdm_pins_t           pin_out,
    output gpdm_pkg::gpdm_pins_t           pin_oe_n,
    input  wire gpdm_pkg::gpdm_timer_out_t timer_out,
    input  wire logic                      lcd_common_two_enable,
    input  wire logic                      lcd_common_three_enable,
    input  wire logic                      low_power_mode,
    output gpdm_pkg::gpdm_periph_in_t      periph_sel,
    output logic                           wakeup_req
);
    logic [7:0] pa_data_q;
    logic [7:0] pa_dir_q;
    logic [6:0] pb_data_q;
    logic [6:0] pb_dir_q;
    logic [2:0] pc_data_q;
    logic [2:0] pc_dir_q;
    logic [7:0] pa_fsel_q;
    logic [6:0] pb_fsel_q;
    logic [7:0] pa_wake_q;
    logic [7:0] pa_prev_q;
    logic       wake_flag_q;
    logic [7:0] rd_byte;
    logic       rd_hit;
    logic [5:0] byte_addr;
    logic       wr_en;
    logic [7:0] wbyte;
    gpdm_pkg::gpdm_bus_state_t bus_q;
    logic       wr_pa_data;
    logic       wr_pa_dir;
    logic       wr_pb_data;
    logic       wr_pb_dir;
    logic       wr_pc_data;
    logic       wr_pc_dir;
    logic       wr_pa_fsel;
    logic       wr_pb_fsel;
    logic       wr_pa_wake;

    // Per-pin routing
    logic [7:0] pa_analog;
    logic [7:0] pa_func_en;
    logic [7:0] pa_func_val;
    logic [6:0] pb_analog;
    logic [6:0] pb_func_en;
    logic [6:0] pb_func_val;
    logic       clkout_en;
    logic       an7_en;
    logic [7:0] pa_out;
    logic [7:0] pa_oe_n;
    logic [6:0] pb_out;
    logic [6:0] pb_oe_n;
    logic [7:0] an_sel;

    assign byte_addr = {avs_address, 2'b00};
    assign wbyte     = avs_writedata[7:0];
    // Write lands on the ack edge, where the master samples waitrequest low
    assign wr_en     = (bus_q == gpdm_pkg::GPDM_BUS_ACK) && avs_write && avs_byteenable[0];

    // One strobe per register keeps each latch in its own process
    assign wr_pa_data = wr_en && (byte_addr == `GPDM_OFF_PA_DATA);
    assign wr_pa_dir  = wr_en && (byte_addr == `GPDM_OFF_PA_DIR);
    assign wr_pb_data = wr_en && (byte_addr == `GPDM_OFF_PB_DATA);
    assign wr_pb_dir  = wr_en && (byte_addr == `GPDM_OFF_PB_DIR);
    assign wr_pc_data = wr_en && (byte_addr == `GPDM_OFF_PC_DATA);
    assign wr_pc_dir  = wr_en && (byte_addr == `GPDM_OFF_PC_DIR);
    assign wr_pa_fsel = wr_en && (byte_addr == `GPDM_OFF_PA_FSEL);
    assign wr_pb_fsel = wr_en && (byte_addr == `GPDM_OFF_PB_FSEL);
    assign wr_pa_wake = wr_en && (byte_addr == `GPDM_OFF_PA_WAKE);

    // One wait state per access so the read mux is registered
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_q <= gpdm_pkg::GPDM_BUS_IDLE;
        end else begin
            case (bus_q)
                gpdm_pkg::GPDM_BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_q <= gpdm_pkg::GPDM_BUS_ACK;
                    end
                end
                gpdm_pkg::GPDM_BUS_ACK: begin
                    bus_q <= gpdm_pkg::GPDM_BUS_IDLE;
                end
                default: begin
                    bus_q <= gpdm_pkg::GPDM_BUS_IDLE;
                end
            endcase
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && (bus_q != gpdm_pkg::GPDM_BUS_ACK);

    // Data latches hold until software writes them again
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pa_data_q <= `GPDM_RST_PA_DATA;
        end else if (wr_pa_data) begin
            pa_data_q <= wbyte;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pb_data_q <= `GPDM_RST_PB_DATA;
        end else if (wr_pb_data) begin
            pb_data_q <= wbyte[6:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pc_data_q <= `GPDM_RST_PC_DATA;
        end else if (wr_pc_data) begin
            pc_data_q <= wbyte[2:0];
        end
    end

    // A one in a direction bit makes the pin an input
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pa_dir_q <= `GPDM_RST_PA_DIR;
        end else if (wr_pa_dir) begin
            pa_dir_q <= wbyte;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pb_dir_q <= `GPDM_RST_PB_DIR;
        end else if (wr_pb_dir) begin
            pb_dir_q <= wbyte[6:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pc_dir_q <= `GPDM_RST_PC_DIR;
        end else if (wr_pc_dir) begin
            pc_dir_q <= wbyte[2:0];
        end
    end

    // Select and wake-enable registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pa_fsel_q <= `GPDM_RST_PA_FSEL;
        end else if (wr_pa_fsel) begin
            pa_fsel_q <= wbyte;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pb_fsel_q <= `GPDM_RST_PB_FSEL;
        end else if (wr_pb_fsel) begin
            pb_fsel_q <= wbyte[6:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pa_wake_q <= `GPDM_RST_PA_WAKE;
        end else if (wr_pa_wake) begin
            pa_wake_q <= wbyte;
        end
    end

    // Port A function decode
    always_comb begin
        pa_analog   = 8'h00;
        pa_func_en  = 8'h00;
        pa_func_val = 8'h00;
        // Bits 7:6 -> pin 7
        pa_analog[7]   = (pa_fsel_q[7:6] == 2'b11);
        pa_func_en[7]  = (pa_fsel_q[7:6] == 2'b01);
        pa_func_val[7] = timer_out.t1_primary;
        // Bits 5:4 -> pin 6; reference output is analog too
        pa_analog[6]   = pa_fsel_q[5];
        // Bits 3:2 -> pin 5
        pa_analog[5]   = pa_fsel_q[3];
        pa_analog[4]   = pa_fsel_q[1];
        pa_func_en[0]  = pa_fsel_q[0];
        pa_func_val[0] = timer_out.t0_primary;
    end

    assign clkout_en = pb_fsel_q[`GPDM_PBF_CLKOUT] && !lcd_common_two_enable;
    assign an7_en    = pb_fsel_q[`GPDM_PBF_AN7] && !lcd_common_three_enable;

    // Port B function decode
    always_comb begin
        pb_analog      = 7'h00;
        pb_func_en     = 7'h00;
        pb_func_val    = 7'h00;
        pb_func_en[6]  = pb_fsel_q[6];
        pb_func_val[6] = timer_out.t1_inverted;
        pb_func_en[5]  = pb_fsel_q[5];
        pb_func_val[5] = timer_out.t0_inverted;
        // Clock output follows sys_clk (8 MHz system in the real part)
        pb_func_en[4]  = clkout_en;
        pb_func_val[4] = sys_clk;
        pb_analog[3]   = an7_en;
        pb_analog[2:0] = pb_fsel_q[2:0];
    end

    // Pin drivers: analog first, then function, then latch
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pa
            logic bit_out;
            logic bit_oe_n;
            always_comb begin
                if (pa_analog[gi]) begin
                    bit_out  = 1'b0;
                    bit_oe_n = 1'b1;
                end else if (pa_func_en[gi]) begin
                    bit_out  = pa_func_val[gi];
                    bit_oe_n = 1'b0;
                end else begin
                    bit_out  = pa_data_q[gi];
                    bit_oe_n = pa_dir_q[gi];
                end
            end
            assign pa_out[gi]  = bit_out;
            assign pa_oe_n[gi] = bit_oe_n;
        end
        for (gi = 0; gi < 7; gi++) begin : g_pb
            logic bit_out;
            logic bit_oe_n;
            always_comb begin
                if (pb_analog[gi]) begin
                    bit_out  = 1'b0;
                    bit_oe_n = 1'b1;
                end else if (pb_func_en[gi]) begin
                    bit_out  = pb_func_val[gi];
                    bit_oe_n = 1'b0;
                end else begin
                    bit_out  = pb_data_q[gi];
                    bit_oe_n = pb_dir_q[gi];
                end
            end
            assign pb_out[gi]  = bit_out;
            assign pb_oe_n[gi] = bit_oe_n;
        end
    endgenerate

    // Port C has no alternate functions; one driver per output struct
    assign pin_out  = '{a: pa_out, b: pb_out, c: pc_data_q};
    assign pin_oe_n = '{a: pa_oe_n, b: pb_oe_n, c: pc_dir_q};

    // Reference codes park the pad but reach no converter input
    assign an_sel[7]   = pb_analog[3];
    assign an_sel[6]   = pa_analog[7];
    assign an_sel[5]   = (pa_fsel_q[5:4] == 2'b11);
    assign an_sel[4]   = (pa_fsel_q[3:2] == 2'b11);
    assign an_sel[3]   = pa_analog[4];
    assign an_sel[2:0] = pb_analog[2:0];

    // Analog inputs fan out to every module that selects them
    assign periph_sel.analog_sel = an_sel;
    assign periph_sel.vref_in_sel        = (pa_fsel_q[3:2] == 2'b10);
    assign periph_sel.vref_out_sel       = (pa_fsel_q[5:4] == 2'b10);
    assign periph_sel.timer1_clock_input = !pa_fsel_q[1];
    assign periph_sel.timer0_clock_input = !pb_fsel_q[2];
    assign periph_sel.ext_int_one        = !pb_fsel_q[1];
    assign periph_sel.ext_int_zero       = !pb_fsel_q[0];

    // Wake on falling edge of an enabled port A pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pa_prev_q <= 8'hFF;
        end else begin
            pa_prev_q <= pin_in.a;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wake_flag_q <= 1'b0;
        end else if (low_power_mode && |(pa_wake_q & pa_prev_q & ~pin_in.a)) begin
            wake_flag_q <= 1'b1;
        end else if (!low_power_mode) begin
            wake_flag_q <= 1'b0;
        end
    end

    assign wakeup_req = wake_flag_q;

    // Read mux: input pins give live level, outputs give the latch
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        case (byte_addr)
            `GPDM_OFF_PA_DATA: rd_byte = (pa_dir_q & pin_in.a) | (~pa_dir_q & pa_data_q);
            `GPDM_OFF_PB_DATA: rd_byte = {1'b0, (pb_dir_q & pin_in.b) | (~pb_dir_q & pb_data_q)};
            `GPDM_OFF_PC_DATA: rd_byte = {5'h00, (pc_dir_q & pin_in.c) | (~pc_dir_q & pc_data_q)};
            `GPDM_OFF_PA_DIR:  rd_byte = pa_dir_q;
            `GPDM_OFF_PB_DIR:  rd_byte = {1'b0, pb_dir_q};
            `GPDM_OFF_PC_DIR:  rd_byte = {5'h00, pc_dir_q};
            `GPDM_OFF_PA_FSEL: rd_byte = pa_fsel_q;
            `GPDM_OFF_PB_FSEL: rd_byte = {1'b0, pb_fsel_q};
            `GPDM_OFF_PA_WAKE: rd_byte = pa_wake_q;
            `GPDM_OFF_STATUS:  rd_byte = {7'h00, wake_flag_q};
            default:           rd_hit  = 1'b0;
        endcase
    end

    // Pins sampled in the request cycle; a bit op is then a read and a write (RMW)
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avs_readdata     <= 32'h0000_0000;
            avs_response_err <= 1'b0;
        end else if (bus_q == gpdm_pkg::GPDM_BUS_IDLE) begin
            avs_readdata     <= {24'h00_0000, rd_byte};
            avs_response_err <= !rd_hit;
        end
    end
endmodule // gpdm_port

// >>> tb/gpdm_props.sv
`timescale 1ns/100ps
module gpdm_props (
    input logic                      sys_clk,
    input logic                      rst,
    input logic [3:0]                avs_address,
    input logic                      avs_read,
    input logic                      avs_write,
    input logic [31:0]               avs_writedata,
    input logic [3:0]                avs_byteenable,
    input logic [31:0]               avs_readdata,
    input logic                      avs_waitrequest,
    input logic                      avs_response_err,
    input gpdm_pkg::gpdm_pins_t      pin_in,
    input gpdm_pkg::gpdm_pins_t      pin_out,
    input gpdm_pkg::gpdm_pins_t      pin_oe_n,
    input gpdm_pkg::gpdm_timer_out_t timer_out,
    input logic                      lcd_common_two_enable,
    input logic                      lcd_common_three_enable,
    input logic                      low_power_mode,
    input gpdm_pkg::gpdm_periph_in_t periph_sel,
    input logic                      wakeup_req
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_no_wr_ack;
        !(avs_write && !avs_waitrequest);
    endsequence
    AST_ONE_WAIT: assert property (s_req |=> !avs_waitrequest)
        else $error("request not answered after one wait state");
    AST_RD_UPPER: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_RST_IN: assert property ($fell(rst) |-> pin_oe_n == 18'h3FFFF && periph_sel.analog_sel == 8'h00)
        else $error("pins not inputs after reset");
    AST_AN_OFF: assert property ((periph_sel.analog_sel & ~{pin_oe_n.b[3], pin_oe_n.a[7:4], pin_oe_n.b[2:0]}) == 8'h00)
        else $error("driver on while analog selected");
    AST_COM3: assert property (lcd_common_three_enable |-> !periph_sel.analog_sel[7])
        else $error("analog seven while common three on");
    AST_WAKE_SRC: assert property ($rose(wakeup_req) |-> $past(low_power_mode))
        else $error("wake outside low power");
    AST_WAKE_CLR: assert property (!low_power_mode |=> !wakeup_req)
        else $error("wake held after low power left");
    AST_PC_HOLD: assert property (s_no_wr_ack |=> $stable(pin_out.c) && $stable(pin_oe_n.c))
        else $error("port C changed without write");
endmodule // gpdm_props
bind gpdm_port gpdm_props i_props (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_err, .pin_in, .pin_out, .pin_oe_n,
    .timer_out, .lcd_common_two_enable, .lcd_common_three_enable, .low_power_mode, .periph_sel, .wakeup_req);

// >>> tb/gpdm_board.sv
`timescale 1ns/100ps
module gpdm_board (
    input  wire gpdm_pkg::gpdm_pins_t pin_out,
    input  wire gpdm_pkg::gpdm_pins_t pin_oe_n,
    input  wire gpdm_pkg::gpdm_pins_t ext,
    input  wire logic                 clash,
    output gpdm_pkg::gpdm_pins_t      pin_in
);
    // Clash models a stiff load that overrides driven pins
    assign pin_in = clash ? ext : ((~pin_oe_n & pin_out) | (pin_oe_n & ext));
endmodule // gpdm_board

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, avs_response_err, wakeup_req;
    logic lcd2, lcd3, lpm, clash;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    gpdm_pkg::gpdm_pins_t pin_in, pin_out, pin_oe_n, ext;
    gpdm_pkg::gpdm_timer_out_t tmr;
    gpdm_pkg::gpdm_periph_in_t psel;
    logic [8:0] exp_q[$];
    logic [7:0] rdv;
    logic [7:0] mk[3] = '{8'hFF, 8'h7F, 8'h07};
    int n_errors = 0;
    int n_compared = 0;
    gpdm_port i_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .timer_out(tmr),
        .lcd_common_two_enable(lcd2), .lcd_common_three_enable(lcd3), .low_power_mode(lpm),
        .periph_sel(psel), .wakeup_req(wakeup_req));
    gpdm_board i_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext), .clash(clash), .pin_in(pin_in));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp_val(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t rd got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] b,
                       input logic [8:0] e);
        @(posedge sys_clk);
        avs_address    <= a;
        avs_read       <= !w;
        avs_write      <= w;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= b;
        if (!w) exp_q.push_back(e);
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1, 9'h000);
    endtask
    task automatic rd(input logic [3:0] a, input logic [8:0] e);
        bus(1'b0, a, 8'h00, 4'h1, e);
    endtask
    // Read results checked where the ack is seen
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            cmp_rd({avs_response_err, avs_readdata[7:0]}, exp_q.pop_front());
    end
    initial begin
        #200000;
        n_errors++;
        test_done();
    end
    initial begin
        logic [17:0] r;
        logic [7:0] rv[10];
        logic [7:0] d[3], m[3], pe[3];
        logic s1, s0;
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= '0;
        {ext, tmr, lcd2, lcd3, lpm, clash} <= '0;
        rst = 1'b1;
        void'($urandom(34477));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        r = 18'($urandom);
        ext <= r;
        repeat (2) @(posedge sys_clk);
        rv = '{r[17:10], 8'hFF, {1'b0, r[9:3]}, 8'h7F, {5'h00, r[2:0]}, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 10; i++) rd(4'(i), {1'b0, rv[i]});
        $display("reset test done");
        clash <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            r = 18'($urandom);
            ext <= r;
            pe = '{r[17:10], {1'b0, r[9:3]}, {5'h00, r[2:0]}};
            for (int p = 0; p < 3; p++) begin
                d[p] = 8'($urandom);
                m[p] = 8'($urandom);
                wr(4'(2 * p), d[p]);
                wr(4'(2 * p + 1), m[p]);
                rd(4'(2 * p + 1), {1'b0, m[p] & mk[p]});
                rd(4'(2 * p), {1'b0, ((d[p] & ~m[p]) | (pe[p] & m[p])) & mk[p]});
            end
            cmp_val(pin_oe_n, {m[0], m[1][6:0], m[2][2:0]});
            cmp_val(pin_out | pin_oe_n, {d[0] | m[0], d[1][6:0] | m[1][6:0], d[2][2:0] | m[2][2:0]});
        end
        rd(4'h1, {1'b0, m[0]});
        wr(4'h1, rdv ^ 8'h10);
        rd(4'h1, {1'b0, m[0] ^ 8'h10});
        bus(1'b1, 4'h5, 8'h00, 4'h0, 9'h000);
        bus(1'b1, 4'hF, 8'hFF, 4'h1, 9'h000);
        rd(4'h5, {1'b0, m[2] & 8'h07});
        rd(4'hF, 9'h100);
        $display("direction test done");
        {clash, tmr} <= 5'h0F;
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h00);
        for (logic [2:0] v = 0; v < 4; v++) begin
            wr(4'h6, {4{v[1:0]}});
            rd(4'h6, {1'b0, {4{v[1:0]}}});
            cmp_val(18'({psel.analog_sel[6:3], psel.vref_out_sel, psel.vref_in_sel, psel.timer1_clock_input}),
                    18'({{3{v == 3}}, v[1], v == 2, v == 2, !v[1]}));
            cmp_val(18'(pin_oe_n.a), (v == 3) ? 18'h000F0 : (v == 2) ? 18'h00070 : 18'h00000);
            if (v == 1) cmp_val(18'({pin_out.a[7], pin_out.a[0]}), 18'h00003);
        end
        $display("port A select test done");
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h00);
        wr(4'h7, 8'hFF);
        rd(4'h7, 9'h07F);
        cmp_val(18'({psel.analog_sel[7], psel.analog_sel[2:0], pin_oe_n.b[3:0], psel.timer0_clock_input,
                     psel.ext_int_one, psel.ext_int_zero}), 18'h007F8);
        cmp_val(18'({pin_out.b[6], pin_out.b[5]}), 18'h00003);
        @(posedge sys_clk);
        #2 s1 = pin_out.b[4];
        @(negedge sys_clk);
        #2 s0 = pin_out.b[4];
        cmp_val(18'({s1, s0}), 18'h00002);
        @(posedge sys_clk);
        lcd2 <= 1'b1;
        lcd3 <= 1'b1;
        repeat (2) @(posedge sys_clk);
        cmp_val(18'(psel.analog_sel[7]), 18'h00000);
        #2 s1 = pin_out.b[4];
        cmp_val(18'({s1, pin_oe_n.b[4], pin_oe_n.b[3]}), 18'h00000);
        $display("port B select test done");
        wr(4'h1, 8'hFF);
        wr(4'h6, 8'h00);
        wr(4'h8, 8'h01);
        ext <= 18'h3FFFF;
        lpm <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ext.a <= 8'hFD;
        repeat (6) @(posedge sys_clk);
        cmp_val(18'(wakeup_req), 18'h00000);
        ext.a <= 8'hFC;
        repeat (6) @(posedge sys_clk);
        cmp_val(18'(wakeup_req), 18'h00001);
        lpm <= 1'b0;
        repeat (3) @(posedge sys_clk);
        cmp_val(18'(wakeup_req), 18'h00000);
        $display("wake test done");
        repeat (3) @(posedge sys_clk);
        test_done();
    end
endmodule // testbench
